// ### core/gsexp_ctrl.sv
/*
 * gsexp_ctrl: global shutter exposure sequencer with apb registers.
 * Assumes an apb master on pclk and an asynchronous trigger pin.
 */
//
// Functional notes
// - pipelined: frame and exposure counts drive timing
// - granularity register scales reset and exposure
// - overhead: transfer to storage, then reset
// - hold reset length, then expose count
// - exposure during readout waits for row overhead
// - stretch exposure until readout finishes
// - frame mode computes reset from frame
// - triggered: rising edge starts timed exposure
// - falling edges ignored; trigger high 100ns
// - triggered: extend exposure past readout end
// - monitor select 5 flags first line
// - slave: trigger high time is exposure
// - slave: extend exposure past readout end
// - extra slopes use extra exposure registers
`timescale 1ns/10ps
module gsexp_ctrl
	import gsexp_pkg::*;
#(
	parameter int OVHD_CYCLES = GSEXP_OVHD_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// pins
	input  wire logic        exposure_trigger_in,
	output logic             line_monitor_out,
	output logic             pixel_reset_out,
	output logic             storage_xfer_out,
	output logic             integrating_out
);
	typedef enum logic [4:0] {
		GSEXP_IDLE  = 5'b00001,
		GSEXP_OVHD  = 5'b00010,
		GSEXP_RESET = 5'b00100,
		GSEXP_WAIT  = 5'b01000,
		GSEXP_EXPO  = 5'b10000
	} gsexp_state_type;

	gsexp_state_type state_reg, state_next;
	logic [31:0] ctrl_reg;
	logic [15:0] frlen_reg, expo_reg, rstlen_reg, gran_reg;
	logic [15:0] expo2_reg, expo3_reg, readout_reg;
	logic [15:0] cnt_reg, cnt_next;
	logic [15:0] gcnt_reg;
	logic [15:0] frame_cnt_reg;
	logic [1:0]  slope_reg;
	logic        trig_s1_reg, trig_s2_reg, trig_d_reg;
	logic        ro_start_reg;
	logic        expo_done_reg;
	logic        ovf_reg;

	// register decode
	wire        acc      = psel && penable;
	wire        wr       = acc && pwrite;
	wire        sel_ctrl = paddr == GSEXP_CTRL_OFF;
	wire        sel_frl  = paddr == GSEXP_FRLEN_OFF;
	wire        sel_exp  = paddr == GSEXP_EXPO_OFF;
	wire        sel_rl   = paddr == GSEXP_RSTLEN_OFF;
	wire        sel_gr   = paddr == GSEXP_GRAN_OFF;
	wire        sel_e2   = paddr == GSEXP_EXPO2_OFF;
	wire        sel_e3   = paddr == GSEXP_EXPO3_OFF;
	wire        sel_ro   = paddr == GSEXP_READOUT_OFF;
	wire        sel_st   = paddr == GSEXP_STATUS_OFF;
	wire        mapped   = sel_ctrl | sel_frl | sel_exp | sel_rl | sel_gr | sel_e2 | sel_e3
		| sel_ro | sel_st;
	wire [1:0]  mode     = ctrl_reg[GSEXP_MODE_LSB +: 2];
	wire        frame_mode = ctrl_reg[GSEXP_FRMODE_BIT];
	wire [1:0]  slopes   = ctrl_reg[GSEXP_SLOPES_LSB +: 2];
	wire [3:0]  mon_sel  = ctrl_reg[GSEXP_MONSEL_LSB +: 4];
	wire        enable   = ctrl_reg[GSEXP_ENABLE_BIT];

	// readout sequencer status
	wire ro_busy, ro_row_oh, ro_line_start, ro_first;

	// trigger edges from the second sync stage only
	wire trig_rise = trig_s2_reg && !trig_d_reg;
	wire trig_fall = !trig_s2_reg && trig_d_reg;

	// one granularity tick; slave mode ignores the scaling
	wire gtick = (gcnt_reg + 16'h1 >= gran_reg) || (gran_reg == 16'h0);

	// exposure length for the current slope
	wire [15:0] expo_len = (slope_reg == 2'h2) ? expo3_reg :
		(slope_reg == 2'h1) ? expo2_reg : expo_reg;
	wire        more_slope = (slope_reg + 2'h1) < slopes;

	// reset length: own register, or frame minus exposure in frame mode
	wire [15:0] fr_rst = (frlen_reg > expo_reg) ? frlen_reg - expo_reg : 16'h1;
	wire [15:0] rst_len = frame_mode ? fr_rst : rstlen_reg;

	wire timed_end  = (mode != GSEXP_MODE_SLAVE) && gtick && (cnt_reg + 16'h1 >= expo_len)
		&& !more_slope;
	wire slave_end  = (mode == GSEXP_MODE_SLAVE) && (trig_fall || expo_done_reg);
	wire ovhd_end   = cnt_reg == 16'(OVHD_CYCLES - 1);

	// next state
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			GSEXP_IDLE: begin
				cnt_next = 16'h0;
				if (enable && mode == GSEXP_MODE_PIPE)
					state_next = GSEXP_RESET;
				else if (enable && trig_rise)
					state_next = GSEXP_WAIT;
			end
			GSEXP_OVHD: begin
				cnt_next = cnt_reg + 16'h1;
				if (ovhd_end) begin
					cnt_next   = 16'h0;
					state_next = (mode == GSEXP_MODE_PIPE && enable) ? GSEXP_RESET
						: GSEXP_IDLE;
				end
			end
			GSEXP_RESET: begin
				if (gtick)
					cnt_next = cnt_reg + 16'h1;
				if (gtick && cnt_reg + 16'h1 >= rst_len) begin
					cnt_next   = 16'h0;
					state_next = GSEXP_WAIT;
				end
			end
			GSEXP_WAIT: begin
				cnt_next = 16'h0;
				if (!ro_busy || ro_line_start)
					state_next = GSEXP_EXPO;
			end
			GSEXP_EXPO: begin
				if (gtick && mode != GSEXP_MODE_SLAVE)
					cnt_next = (cnt_reg + 16'h1 >= expo_len) ? 16'h0 : cnt_reg + 16'h1;
				if ((timed_end || slave_end) && !ro_busy) begin
					cnt_next   = 16'h0;
					state_next = GSEXP_OVHD;
				end
			end
			default: begin
				state_next = GSEXP_IDLE;
				cnt_next   = 16'h0;
			end
		endcase
	end

	// state, counters and trigger synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= GSEXP_IDLE;
			cnt_reg     <= 16'h0;
			gcnt_reg    <= 16'h0;
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_d_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			gcnt_reg    <= (gtick || state_next != state_reg) ? 16'h0 : gcnt_reg + 16'h1;
			trig_s1_reg <= exposure_trigger_in;
			trig_s2_reg <= trig_s1_reg;
			trig_d_reg  <= trig_s2_reg;
		end
	end

	// slope index, exposure-done latch and readout kick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slope_reg     <= 2'h0;
			expo_done_reg <= 1'b0;
			ro_start_reg  <= 1'b0;
			frame_cnt_reg <= 16'h0;
			ovf_reg       <= 1'b0;
		end else begin
			ro_start_reg <= state_reg == GSEXP_OVHD && ovhd_end;
			if (state_reg != GSEXP_EXPO)
				slope_reg <= 2'h0;
			else if (mode != GSEXP_MODE_SLAVE && gtick && cnt_reg + 16'h1 >= expo_len
				&& more_slope)
				slope_reg <= slope_reg + 2'h1;
			// a fall while waiting for a line start must not be lost, or slave hangs
			if (state_reg != GSEXP_EXPO && state_reg != GSEXP_WAIT)
				expo_done_reg <= 1'b0;
			else if (trig_fall)
				expo_done_reg <= 1'b1;
			if (state_reg == GSEXP_OVHD && ovhd_end)
				frame_cnt_reg <= frame_cnt_reg + 16'h1;
			// rising edge during overhead breaks the controller's side
			if (state_reg == GSEXP_OVHD && trig_rise)
				ovf_reg <= 1'b1;
			else if (wr && sel_st && pwdata[0])
				ovf_reg <= 1'b0;
		end
	end

	// apb write side; zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg    <= GSEXP_CTRL_RST;
			frlen_reg   <= GSEXP_FRLEN_RST;
			expo_reg    <= GSEXP_EXPO_RST;
			rstlen_reg  <= GSEXP_RSTLEN_RST;
			gran_reg    <= GSEXP_GRAN_RST;
			expo2_reg   <= GSEXP_EXPO_RST;
			expo3_reg   <= GSEXP_EXPO_RST;
			readout_reg <= GSEXP_READOUT_RST;
		end else if (wr) begin
			if (sel_ctrl) ctrl_reg    <= pwdata;
			if (sel_frl)  frlen_reg   <= pwdata[15:0];
			if (sel_exp)  expo_reg    <= pwdata[15:0];
			if (sel_rl)   rstlen_reg  <= pwdata[15:0];
			if (sel_gr)   gran_reg    <= pwdata[15:0];
			if (sel_e2)   expo2_reg   <= pwdata[15:0];
			if (sel_e3)   expo3_reg   <= pwdata[15:0];
			if (sel_ro)   readout_reg <= pwdata[15:0];
		end
	end

	// read mux
	wire [31:0] status_word = {frame_cnt_reg, 7'h0, ovf_reg, 2'h0, ro_busy, state_reg};
	wire [31:0] rd_mux =
		sel_ctrl ? ctrl_reg :
		sel_frl  ? {16'h0, frlen_reg} :
		sel_exp  ? {16'h0, expo_reg} :
		sel_rl   ? {16'h0, rstlen_reg} :
		sel_gr   ? {16'h0, gran_reg} :
		sel_e2   ? {16'h0, expo2_reg} :
		sel_e3   ? {16'h0, expo3_reg} :
		sel_ro   ? {16'h0, readout_reg} :
		sel_st   ? status_word : 32'h0;

	// registered apb answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// pin outputs from flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_monitor_out <= 1'b0;
			pixel_reset_out  <= 1'b1;
			storage_xfer_out <= 1'b0;
			integrating_out  <= 1'b0;
		end else begin
			line_monitor_out <= (mon_sel == GSEXP_MON_FIRST_LINE) ? ro_first
				: ro_line_start;
			pixel_reset_out  <= state_next == GSEXP_RESET || state_next == GSEXP_WAIT
				|| state_next == GSEXP_IDLE || (state_next == GSEXP_OVHD && cnt_next > 16'h3);
			storage_xfer_out <= state_next == GSEXP_OVHD && cnt_next <= 16'h3;
			integrating_out  <= state_next == GSEXP_EXPO;
		end
	end

	// readout engine, started after the overhead transfer
	gsexp_readout u_readout (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (ro_start_reg),
		.line_total (readout_reg),
		.busy       (ro_busy),
		.in_row_oh  (ro_row_oh),
		.line_start (ro_line_start),
		.first_line (ro_first)
	);

endmodule

// ### core/gsexp_pkg.sv
/*
 * gsexp_pkg: constants shared by the global shutter exposure controller.
 * Assumes nothing; holds register offsets, field positions, mode and monitor codes,
 * reset values and timing constants only.
 */
package gsexp_pkg;

	// register byte offsets on the apb slave
	localparam logic [7:0] GSEXP_CTRL_OFF      = 8'h00;
	localparam logic [7:0] GSEXP_FRLEN_OFF     = 8'h04;
	localparam logic [7:0] GSEXP_EXPO_OFF      = 8'h08;
	localparam logic [7:0] GSEXP_RSTLEN_OFF    = 8'h0c;
	localparam logic [7:0] GSEXP_GRAN_OFF      = 8'h10;
	localparam logic [7:0] GSEXP_EXPO2_OFF     = 8'h14;
	localparam logic [7:0] GSEXP_EXPO3_OFF     = 8'h18;
	localparam logic [7:0] GSEXP_READOUT_OFF   = 8'h1c;
	localparam logic [7:0] GSEXP_STATUS_OFF    = 8'h20;

	// control register fields
	localparam int GSEXP_MODE_LSB    = 0;   // 2 bits: operating mode
	localparam int GSEXP_FRMODE_BIT  = 2;   // frame_time_mode_select
	localparam int GSEXP_SLOPES_LSB  = 3;   // 2 bits: slope count 1..3
	localparam int GSEXP_MONSEL_LSB  = 8;   // 4 bits: monitor source select
	localparam int GSEXP_ENABLE_BIT  = 15;

	// operating modes
	localparam logic [1:0] GSEXP_MODE_PIPE = 2'h0;
	localparam logic [1:0] GSEXP_MODE_TRIG = 2'h1;
	localparam logic [1:0] GSEXP_MODE_SLAVE = 2'h2;

	// monitor source that flags the first line
	localparam logic [3:0] GSEXP_MON_FIRST_LINE = 4'h5;

	// reset values
	localparam logic [31:0] GSEXP_CTRL_RST    = 32'h0000_0008;
	localparam logic [15:0] GSEXP_FRLEN_RST   = 16'h1000;
	localparam logic [15:0] GSEXP_EXPO_RST    = 16'h0800;
	localparam logic [15:0] GSEXP_RSTLEN_RST  = 16'h0010;
	localparam logic [15:0] GSEXP_GRAN_RST    = 16'h0001;
	localparam logic [15:0] GSEXP_READOUT_RST = 16'h0400;

	// timing: frame overhead length and trigger pulse minimum
	localparam int GSEXP_CLK_PS         = 4000;
	localparam int GSEXP_OVHD_CYCLES    = 64;
	localparam int GSEXP_ROWOH_CYCLES   = 8;
	localparam int GSEXP_LINE_CYCLES    = 64;
	localparam int GSEXP_TRIG_MIN_NS    = 100;
	localparam int GSEXP_TRIG_MIN_CYC   = (GSEXP_TRIG_MIN_NS * 1000 + GSEXP_CLK_PS - 1)
		/ GSEXP_CLK_PS;

endpackage

// ### core/gsexp_readout.sv
/*
 * gsexp_readout: line-by-line readout sequencer.
 * Assumes a start pulse from the exposure controller; one clock domain.
 */
`timescale 1ns/10ps
module gsexp_readout
	import gsexp_pkg::*;
#(
	parameter int LINE_CYCLES = GSEXP_LINE_CYCLES,
	parameter int ROWOH_CYCLES = GSEXP_ROWOH_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control
	input  wire logic        start,
	input  wire logic [15:0] line_total,
	// status
	output logic             busy,
	output logic             in_row_oh,
	output logic             line_start,
	output logic             first_line
);
	logic [15:0] line_reg;
	logic [15:0] cyc_reg;
	wire         line_end = busy && (cyc_reg == 16'(LINE_CYCLES - 1));
	wire         last     = line_end && (line_reg + 16'h1 >= line_total);

	// line and cycle counters; row overhead heads each line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy       <= 1'b0;
			line_reg   <= 16'h0;
			cyc_reg    <= 16'h0;
			line_start <= 1'b0;
			first_line <= 1'b0;
			in_row_oh  <= 1'b0;
		end else begin
			line_start <= (start && !busy) || (line_end && !last);
			first_line <= start && !busy;
			if (start && !busy) begin
				busy     <= 1'b1;
				line_reg <= 16'h0;
				cyc_reg  <= 16'h0;
				in_row_oh <= 1'b1;
			end else if (busy) begin
				cyc_reg <= line_end ? 16'h0 : cyc_reg + 16'h1;
				in_row_oh <= line_end ? !last : (cyc_reg < 16'(ROWOH_CYCLES - 1));
				if (line_end)
					line_reg <= line_reg + 16'h1;
				if (last)
					busy <= 1'b0;
			end
		end
	end
endmodule

// ### verification/gsexp_ctrl_assertions.sv
/* gsexp_ctrl_assertions: port checks on the exposure sequencer.
   assumes a bind onto gsexp_ctrl; sees its ports only. */
`timescale 1ns/10ps
module gsexp_ctrl_assertions #(
	parameter int OVHD_CYCLES = 64
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire logic line_monitor_out,
	input wire logic pixel_reset_out,
	input wire logic storage_xfer_out,
	input wire logic integrating_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// zero wait states, answer only in access
	property p_apb_ans; psel && !penable |=> pready; endproperty
	a_apb_ans: assert property (p_apb_ans) else $error("no answer after setup");
	property p_rdy_acc; pready |-> psel && penable; endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	// transfer then reset of photodiodes
	property p_xfer_len;
		$rose(storage_xfer_out) |-> storage_xfer_out[*4] ##1 !storage_xfer_out;
	endproperty
	a_xfer_len: assert property (p_xfer_len) else $error("transfer not 4 cycles");
	property p_xfer_rst; $fell(storage_xfer_out) |-> pixel_reset_out; endproperty
	a_xfer_rst: assert property (p_xfer_rst) else $error("no reset after transfer");
	// exposure excludes reset and transfer
	property p_excl; integrating_out |-> !pixel_reset_out && !storage_xfer_out; endproperty
	a_excl: assert property (p_excl) else $error("exposure overlaps reset");
	property p_start; $rose(integrating_out) |-> $past(pixel_reset_out); endproperty
	a_start: assert property (p_start) else $error("exposure not from reset");
	property p_end; $fell(integrating_out) |-> ##[0:2] storage_xfer_out; endproperty
	a_end: assert property (p_end) else $error("exposure end without transfer");
	property p_mon; line_monitor_out |=> !line_monitor_out; endproperty
	a_mon: assert property (p_mon) else $error("monitor pulse too long");
endmodule

bind gsexp_ctrl gsexp_ctrl_assertions #(.OVHD_CYCLES(OVHD_CYCLES)) u_gsexp_ctrl_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .line_monitor_out(line_monitor_out),
	.pixel_reset_out(pixel_reset_out), .storage_xfer_out(storage_xfer_out),
	.integrating_out(integrating_out));

// ### verification/gsexp_ctrl_tb.sv
/* gsexp_ctrl_tb: self-checking bench for the exposure sequencer.
   assumes gsexp_ctrl, its checker bind and the trigger model. */
`timescale 1ns/10ps
module gsexp_ctrl_tb
	import gsexp_pkg::*;
;
	typedef struct packed {logic [31:0] data; logic rd; logic err;} gsexp_note_type;
	typedef struct {int lo; int hi;} gsexp_span_type;
	localparam logic [7:0] RB [3] = '{GSEXP_FRLEN_OFF, GSEXP_EXPO2_OFF, GSEXP_EXPO3_OFF};
	logic           pclk = 1'b0;
	logic           presetn = 1'b0;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [7:0]     paddr = 8'h00;
	logic [31:0]    pwdata = 32'h0;
	logic [31:0]    prdata;
	logic           pready, pslverr, trig, mon, pix_rst, xfer, integ;
	int             miscompares = 0;
	int             checks_done = 0;
	int             ilen = 0;
	gsexp_note_type nq[$];
	gsexp_note_type nt;
	gsexp_span_type sq[$];
	gsexp_span_type sp;

	always #2 pclk = ~pclk;

	gsexp_ctrl u_gsexp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exposure_trigger_in(trig), .line_monitor_out(mon),
		.pixel_reset_out(pix_rst), .storage_xfer_out(xfer), .integrating_out(integ));
	gsexp_trig_model u_gsexp_trig_model (.pclk(pclk), .line_monitor_out(mon),
		.exposure_trigger_in(trig));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic er);
		nq.push_back('{e, !w, er});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic settle;
		wait (sq.size() == 0);
		repeat (600) @(posedge pclk);
	endtask

	task automatic tally_and_finish;
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// results against the oldest note: apb answers and exposure lengths
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			nt = nq.pop_front();
			checks_done++;
			if (pslverr !== nt.err || (nt.rd && prdata !== nt.data)) begin
				miscompares++;
				$display("[FAIL] apb %h: expected %h/%b seen %h/%b", paddr, nt.data, nt.err,
					prdata, pslverr);
			end
		end
		if (integ === 1'b1)
			ilen <= ilen + 1;
		else if (ilen != 0) begin
			ilen <= 0;
			if (sq.size() > 0) begin
				sp = sq.pop_front();
				checks_done++;
				if (ilen < sp.lo || ilen > sp.hi) begin
					miscompares++;
					$display("[FAIL] exposure: expected %0d..%0d seen %0d", sp.lo, sp.hi, ilen);
				end
			end
		end
	end

	// hang guard, well past the expected run length
	initial begin
		#300000;
		miscompares++;
		tally_and_finish;
	end

	initial begin
		logic [31:0] r;
		int          m;
		void'($urandom(24));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unmapped places, random readback
		apb(1'b0, GSEXP_CTRL_OFF, 32'h0, GSEXP_CTRL_RST, 1'b0);
		apb(1'b0, GSEXP_FRLEN_OFF, 32'h0, {16'h0, GSEXP_FRLEN_RST}, 1'b0);
		apb(1'b0, GSEXP_EXPO_OFF, 32'h0, {16'h0, GSEXP_EXPO_RST}, 1'b0);
		apb(1'b0, GSEXP_RSTLEN_OFF, 32'h0, {16'h0, GSEXP_RSTLEN_RST}, 1'b0);
		apb(1'b0, GSEXP_GRAN_OFF, 32'h0, {16'h0, GSEXP_GRAN_RST}, 1'b0);
		apb(1'b0, GSEXP_READOUT_OFF, 32'h0, {16'h0, GSEXP_READOUT_RST}, 1'b0);
		apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h28, 32'hffff_ffff, 32'h0, 1'b1);
		for (m = 0; m < 4; m++) begin
			r = $urandom();
			apb(1'b1, RB[m % 3], r, 32'h0, 1'b0);
			apb(1'b0, RB[m % 3], 32'h0, {16'h0, r[15:0]}, 1'b0);
		end
		// triggered then slave, second pulse paced by the first-line flag
		apb(1'b1, GSEXP_EXPO_OFF, 32'h1e, 32'h0, 1'b0);
		apb(1'b1, GSEXP_GRAN_OFF, 32'h1, 32'h0, 1'b0);
		apb(1'b1, GSEXP_FRLEN_OFF, 32'h1, 32'h0, 1'b0);
		apb(1'b1, GSEXP_READOUT_OFF, 32'h2, 32'h0, 1'b0);
		for (m = 1; m < 3; m++) begin
			apb(1'b1, GSEXP_CTRL_OFF, 32'h8508 | m, 32'h0, 1'b0);
			sq.push_back('{m == 1 ? 30 : 78, m == 1 ? 30 : 82});
			u_gsexp_trig_model.pulse(m == 1 ? 25 : 80, 1'b0);
			sq.push_back('{m == 1 ? 30 : 8, 4000});
			u_gsexp_trig_model.pulse(m == 1 ? 25 : 10, 1'b1);
			settle;
		end
		// pipelined: reset 100x2, exposure 20x2
		apb(1'b1, GSEXP_RSTLEN_OFF, 32'h64, 32'h0, 1'b0);
		apb(1'b1, GSEXP_GRAN_OFF, 32'h2, 32'h0, 1'b0);
		apb(1'b1, GSEXP_EXPO_OFF, 32'h14, 32'h0, 1'b0);
		apb(1'b1, GSEXP_READOUT_OFF, 32'h1, 32'h0, 1'b0);
		sq.push_back('{40, 40});
		apb(1'b1, GSEXP_CTRL_OFF, 32'h8008, 32'h0, 1'b0);
		settle;
		// short exposure under a long readout gets stretched
		apb(1'b1, GSEXP_EXPO_OFF, 32'h2, 32'h0, 1'b0);
		apb(1'b1, GSEXP_GRAN_OFF, 32'h1, 32'h0, 1'b0);
		apb(1'b1, GSEXP_RSTLEN_OFF, 32'h1, 32'h0, 1'b0);
		apb(1'b1, GSEXP_READOUT_OFF, 32'h4, 32'h0, 1'b0);
		wait (integ === 1'b1);
		wait (integ === 1'b0);
		repeat (2) @(posedge pclk);
		sq.push_back('{128, 4000});
		settle;
		tally_and_finish;
	end
endmodule

// ### verification/gsexp_trig_model.sv
/* gsexp_trig_model: camera controller driving the trigger pin.
   assumes pulses are requested by the bench through the pulse task. */
`timescale 1ns/10ps
module gsexp_trig_model
	import gsexp_pkg::*;
(
	// clock and feedback
	input wire logic pclk,
	input wire logic line_monitor_out,
	// trigger pin
	output logic     exposure_trigger_in
);
	initial exposure_trigger_in = 1'b0;

	// one pulse, optionally paced by the first-line flag
	task automatic pulse(input int hi, input bit after_mon);
		int n;
		n = (hi < GSEXP_TRIG_MIN_CYC) ? GSEXP_TRIG_MIN_CYC : hi;
		if (after_mon)
			@(posedge pclk iff line_monitor_out === 1'b1);
		@(posedge pclk);
		exposure_trigger_in <= 1'b1;
		repeat (n) @(posedge pclk);
		exposure_trigger_in <= 1'b0;
	endtask
endmodule
